// file: src/mcl_logger.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module mcl_logger
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire  logic              clk,
  input  wire  logic              rst,
  // Error event
  input  wire  mcl_evt_type       evt,
  // AXI4-Lite write
  input  wire  logic [AXI_AW-1:0] s_awaddr,
  input  wire  logic              s_awvalid,
  output logic                    s_awready,
  input  wire  logic [31:0]       s_wdata,
  input  wire  logic [3:0]        s_wstrb,
  input  wire  logic              s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire  logic              s_bready,
  // AXI4-Lite read
  input  wire  logic [AXI_AW-1:0] s_araddr,
  input  wire  logic              s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire  logic              s_rready,
  // Interrupt
  output logic                    irq
);

  // ----------------------------------------
  // Log state
  // ----------------------------------------
  logic [7:0]       cnt_r,   cnt_nxt;
  logic [1:0]       fmt_r,   fmt_nxt;
  logic [7:0]       syn_r,   syn_nxt;
  logic             synv_r,  synv_nxt;
  logic [1:0]       hlth_r,  hlth_nxt;
  logic [15:0]      msec_r,  msec_nxt;
  logic             extra_info_valid_flag_r, extra_info_valid_flag_nxt;
  logic             uc_r,    uc_nxt;
  logic             val_r,   val_nxt;
  logic [IRQ_W-1:0] ist_r,   ist_nxt;
  logic [IRQ_W-1:0] imsk_r,  imsk_nxt;
  logic             irq_r,   irq_nxt;

  // Bus state
  logic              awh_r, awh_nxt;
  logic              wh_r,  wh_nxt;
  logic [AXI_AW-1:0] wa_r,  wa_nxt;
  logic [31:0]       wd_r,  wd_nxt;
  logic [3:0]        ws_r,  ws_nxt;
  logic              awr_r, awr_nxt;
  logic              wr_r,  wr_nxt;
  logic              bv_r,  bv_nxt;
  logic [1:0]        br_r,  br_nxt;
  logic              arr_r, arr_nxt;
  logic              rv_r,  rv_nxt;
  logic [31:0]       rd_r,  rd_nxt;
  logic [1:0]        rr_r,  rr_nxt;

  logic [63:0]       stat;
  logic [2:0]        l3_code;
  logic [15:0]       cache_msec;
  logic              do_wr;
  logic              clr_val;
  logic              ce_evt;
  logic              take;
  logic [IRQ_W-1:0]  ev_set;
  logic [IRQ_W-1:0]  ist_clr;

  function automatic logic multi(input logic [NWAYS-1:0] v);
    multi = |(v & (v - NWAYS'(1)));
  endfunction

  // ----------------------------------------
  // Cache way encoding
  // ----------------------------------------
  always_comb begin
    // Mixed wins: it says most about the set
    if (|evt.ce_ways && |evt.ue_ways) begin
      l3_code = L3_MIXED;
    end else if (multi(evt.ue_ways)) begin
      l3_code = L3_MULTI_UE;
    end else if (|evt.ue_ways) begin
      l3_code = L3_ONE_UE;
    end else if (multi(evt.tag_ways)) begin
      l3_code = L3_MULTI_TAG;
    end else if (multi(evt.ce_ways)) begin
      l3_code = L3_MULTI_CE;
    end else if (|evt.ce_ways) begin
      l3_code = L3_ONE_CE;
    end else begin
      l3_code = L3_NONE;
    end
    cache_msec = {CACHE_FIXED, 2'b00, l3_code};
  end

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  always_comb begin
    stat                          = '0;
    stat[MSEC_LSB +: 16]          = msec_r;
    stat[CNT_LSB +: 8]            = cnt_r;
    stat[FMT_LSB +: 2]            = extra_info_valid_flag_r ? fmt_r : 2'b00;
    stat[SYN_LSB +: 8]            = synv_r ? syn_r : 8'h00;
    stat[SYNV_BIT]                = synv_r;
    stat[HLTH_LSB +: 2]           = val_r ? hlth_r : HLTH_NONE;
    stat[EXTRA_INFO_VALID_FLAG_BIT]               = extra_info_valid_flag_r;
    stat[UC_BIT]                  = uc_r;
    stat[VAL_BIT]                 = val_r;
  end

  // ----------------------------------------
  // Logging
  // ----------------------------------------
  always_comb begin
    do_wr   = awh_r && wh_r && !bv_r;
    clr_val = do_wr && wa_r == OFS_STAT_HI && ws_r[3] && wd_r[VAL_HI_BIT];
    ce_evt  = evt.valid && !evt.uc;
    // An uncorrected entry still pending is never overwritten
    take    = evt.valid && !(val_r && uc_r);
    ev_set  = '0;
    ev_set[IRQ_LOGGED] = take;
    ev_set[IRQ_CE]     = ce_evt;
    ev_set[IRQ_UE]     = evt.valid && evt.uc;
    ev_set[IRQ_SAT]    = ce_evt && cnt_r == CNT_MAX - 8'h01;
    ev_set[IRQ_OVER]   = evt.valid && val_r;

    cnt_nxt   = cnt_r;
    fmt_nxt   = fmt_r;
    syn_nxt   = syn_r;
    synv_nxt  = synv_r;
    hlth_nxt  = hlth_r;
    msec_nxt  = msec_r;
    extra_info_valid_flag_nxt = extra_info_valid_flag_r;
    uc_nxt    = uc_r;
    val_nxt   = val_r;

    if (ce_evt && cnt_r != CNT_MAX) begin
      cnt_nxt = cnt_r + CNT_FIRST;
    end
    if (clr_val) begin
      val_nxt = 1'b0;
    end
    if (take) begin
      val_nxt   = 1'b1;
      uc_nxt    = evt.uc;
      extra_info_valid_flag_nxt = evt.misc_valid;
      fmt_nxt   = evt.misc_fmt;
      synv_nxt  = ce_evt && evt.syn_valid;
      syn_nxt   = (ce_evt && evt.syn_valid) ? evt.syndrome : 8'h00;
      // Health is undefined under UC; report no tracking then
      hlth_nxt  = evt.uc ? HLTH_NONE : evt.health;
      msec_nxt  = (evt.kind == KIND_CACHE) ? cache_msec : evt.msec;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    ist_clr  = '0;
    imsk_nxt = imsk_r;
    if (do_wr && wa_r == OFS_IRQ_STAT && ws_r[0]) begin
      ist_clr = wd_r[IRQ_W-1:0];
    end
    if (do_wr && wa_r == OFS_IRQ_MASK && ws_r[0]) begin
      imsk_nxt = wd_r[IRQ_W-1:0];
    end
    // Set beats a clear in the same cycle
    ist_nxt = (ist_r & ~ist_clr) | ev_set;
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_comb begin
    awh_nxt = awh_r;
    wh_nxt  = wh_r;
    wa_nxt  = wa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    if (s_awvalid && awr_r) begin
      awh_nxt = 1'b1;
      wa_nxt  = s_awaddr;
    end
    if (s_wvalid && wr_r) begin
      wh_nxt = 1'b1;
      wd_nxt = s_wdata;
      ws_nxt = s_wstrb;
    end
    if (do_wr) begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = (wa_r == OFS_STAT_LO || wa_r == OFS_STAT_HI ||
                 wa_r == OFS_IRQ_STAT || wa_r == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_r && s_bready) begin
      bv_nxt = 1'b0;
    end
    if (s_arvalid && arr_r) begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      unique case (s_araddr)
        OFS_STAT_LO:  rd_nxt = stat[31:0];
        OFS_STAT_HI:  rd_nxt = stat[63:32];
        OFS_IRQ_STAT: rd_nxt = {{(32-IRQ_W){1'b0}}, ist_r};
        OFS_IRQ_MASK: rd_nxt = {{(32-IRQ_W){1'b0}}, imsk_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rv_r && s_rready) begin
      rv_nxt = 1'b0;
    end
    // Ready drops while a beat is held, which stalls the master
    awr_nxt = !awh_nxt;
    wr_nxt  = !wh_nxt;
    arr_nxt = !rv_nxt;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r   <= 8'h00;
      fmt_r   <= 2'b00;
      syn_r   <= 8'h00;
      synv_r  <= 1'b0;
      hlth_r  <= HLTH_NONE;
      msec_r  <= 16'h0000;
      extra_info_valid_flag_r <= 1'b0;
      uc_r    <= 1'b0;
      val_r   <= 1'b0;
      ist_r   <= '0;
      imsk_r  <= '0;
      irq_r   <= 1'b0;
      awh_r   <= 1'b0;
      wh_r    <= 1'b0;
      wa_r    <= '0;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      awr_r   <= 1'b0;
      wr_r    <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= RESP_OKAY;
      arr_r   <= 1'b0;
      rv_r    <= 1'b0;
      rd_r    <= 32'h0000_0000;
      rr_r    <= RESP_OKAY;
    end else begin
      cnt_r   <= cnt_nxt;
      fmt_r   <= fmt_nxt;
      syn_r   <= syn_nxt;
      synv_r  <= synv_nxt;
      hlth_r  <= hlth_nxt;
      msec_r  <= msec_nxt;
      extra_info_valid_flag_r <= extra_info_valid_flag_nxt;
      uc_r    <= uc_nxt;
      val_r   <= val_nxt;
      ist_r   <= ist_nxt;
      imsk_r  <= imsk_nxt;
      irq_r   <= irq_nxt;
      awh_r   <= awh_nxt;
      wh_r    <= wh_nxt;
      wa_r    <= wa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      awr_r   <= awr_nxt;
      wr_r    <= wr_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      arr_r   <= arr_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rr_r    <= rr_nxt;
    end
  end

  assign s_awready = awr_r;
  assign s_wready  = wr_r;
  assign s_bvalid  = bv_r;
  assign s_bresp   = br_r;
  assign s_arready = arr_r;
  assign s_rvalid  = rv_r;
  assign s_rdata   = rd_r;
  assign s_rresp   = rr_r;
  assign irq       = irq_r;

endmodule

`default_nettype wire

// file: src/mcl_pkg.sv
package mcl_pkg;

  // ----------------------------------------
  // Bus map
  // ----------------------------------------
  localparam int         AXI_AW       = 4;
  localparam logic [3:0] OFS_STAT_LO  = 4'h0;
  localparam logic [3:0] OFS_STAT_HI  = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ----------------------------------------
  // Status register fields (64-bit positions)
  // ----------------------------------------
  localparam int MSEC_LSB   = 16;
  localparam int CNT_LSB    = 32;
  localparam int FMT_LSB    = 40;
  localparam int SYN_LSB    = 44;
  localparam int SYNV_BIT   = 52;
  localparam int HLTH_LSB   = 53;
  localparam int EXTRA_INFO_VALID_FLAG_BIT  = 59;
  localparam int UC_BIT     = 61;
  localparam int VAL_BIT    = 63;
  localparam int VAL_HI_BIT = VAL_BIT - 32;

  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  CNT_FIRST   = 8'h01;
  localparam logic [10:0] CACHE_FIXED = 11'b0010_0000_000;
  localparam logic [1:0]  HLTH_NONE   = 2'h0;

  // Cache way codes
  localparam logic [2:0] L3_NONE     = 3'b000;
  localparam logic [2:0] L3_MULTI_CE = 3'b001;
  localparam logic [2:0] L3_MULTI_UE = 3'b010;
  localparam logic [2:0] L3_MULTI_TAG= 3'b011;
  localparam logic [2:0] L3_ONE_CE   = 3'b101;
  localparam logic [2:0] L3_ONE_UE   = 3'b110;
  localparam logic [2:0] L3_MIXED    = 3'b111;

  localparam int NWAYS = 8;
  localparam int IRQ_W = 5;

  // Interrupt status bits
  localparam int IRQ_LOGGED = 0;
  localparam int IRQ_CE     = 1;
  localparam int IRQ_UE     = 2;
  localparam int IRQ_SAT    = 3;
  localparam int IRQ_OVER   = 4;

  typedef enum logic [2:0] {
    KIND_CACHE = 3'b001,
    KIND_BUS   = 3'b010,
    KIND_CTL   = 3'b100
  } mcl_kind_type;

  typedef struct packed {
    logic               valid;
    mcl_kind_type       kind;
    logic               uc;
    logic [NWAYS-1:0]   ce_ways;
    logic [NWAYS-1:0]   ue_ways;
    logic [NWAYS-1:0]   tag_ways;
    logic [15:0]        msec;
    logic               syn_valid;
    logic [7:0]         syndrome;
    logic               misc_valid;
    logic [1:0]         misc_fmt;
    logic [1:0]         health;
  } mcl_evt_type;

endpackage

// file: tb/mcl_logger_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mcl_logger_checker
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Watched ports
  input  wire mcl_evt_type       evt,
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  input  wire logic              s_arready,
  input  wire logic              s_rvalid,
  input  wire logic [31:0]       s_rdata
);
  // ----
  // Read address and count model
  // ----
  logic       hi_r;
  logic       hi_nxt;
  logic       lo_r;
  logic       lo_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb begin
    hi_nxt  = hi_r;
    lo_nxt  = lo_r;
    cnt_nxt = cnt_r;
    if (s_arvalid && s_arready) begin
      hi_nxt = s_araddr == OFS_STAT_HI;
      lo_nxt = s_araddr == OFS_STAT_LO;
    end
    // Saturate, never wrap
    if (evt.valid && !evt.uc && cnt_r != CNT_MAX) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    hi_r  <= rst ? 1'b0 : hi_nxt;
    lo_r  <= rst ? 1'b0 : lo_nxt;
    cnt_r <= rst ? 8'h00 : cnt_nxt;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hi_rd;
    s_rvalid && hi_r;
  endsequence
  sequence s_lo_rd;
    s_rvalid && lo_r;
  endsequence
  // Read data is captured at the address edge, so it shows the count from the cycle before
  a_cnt_model: assert property ($rose(s_rvalid) && hi_r |-> s_rdata[7:0] == $past(cnt_r))
    else $error("event count wrong");
  a_fmt_gate: assert property (s_hi_rd ##0 !s_rdata[27] |-> s_rdata[9:8] == 2'h0)
    else $error("format shown without flag");
  a_syn_gate: assert property (s_hi_rd ##0 !s_rdata[20] |-> s_rdata[19:12] == 8'h00)
    else $error("syndrome shown without flag");
  a_hlth_gate: assert property (s_hi_rd ##0 (!s_rdata[31] || s_rdata[29]) |-> s_rdata[22:21] == 2'h0)
    else $error("health shown when not valid");
  a_hlth_code: assert property (s_hi_rd |-> s_rdata[22:21] != 2'h3)
    else $error("reserved health code");
  a_rsv_low: assert property (s_hi_rd |-> s_rdata[11:10] == 2'h0)
    else $error("reserved low bits set");
  a_rsv_high: assert property (s_hi_rd |-> s_rdata[24:23] == 2'h0)
    else $error("reserved high bits set");
  a_cache_rsv: assert property (s_lo_rd ##0 s_rdata[31:21] == CACHE_FIXED |-> s_rdata[20:19] == 2'h0)
    else $error("cache reserved bits set");
endmodule
`default_nettype wire

// file: tb/mcl_logger_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module mcl_logger_test
  import mcl_pkg::*;
;
  logic              clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [AXI_AW-1:0] s_awaddr, s_araddr;
  logic [3:0]        s_wstrb;
  logic [31:0]       s_wdata, s_rdata, d;
  logic [1:0]        s_bresp, s_rresp, br, rr;
  mcl_evt_type       evt, e;
  int                num_errors, compares, cyc;
  logic [7:0]        ce_t [7] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
  logic [7:0]        ue_t [7] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h02};
  logic [7:0]        tg_t [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [2:0]        cd_t [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  // Running count of correctable events after each cache case
  logic [7:0]        cn_t [7] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04};
  mcl_logger mcl_logger_i (
    .clk       (clk),
    .rst       (rst),
    .evt       (evt),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .irq       (irq)
  );
  // ----
  // Bus tasks
  // ----
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    s_awaddr  <= a;
    s_wdata   <= v;
    s_wstrb   <= s;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    br = s_bresp;
    s_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    v = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
    @(posedge clk);
  endtask
  // Holding valid for n cycles gives n back-to-back events
  task automatic ev(input mcl_evt_type x, input int n);
    evt <= x;
    repeat (n) @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask
  task automatic clr;
    wr(OFS_STAT_HI, 32'h8000_0000, 4'h8);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Clock and watchdog
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
    evt = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_STAT_HI, d);
    `CHK("reset hi", 32'h0000_0000, d)
    `CHK("read resp", RESP_OKAY, rr)
    for (int i = 0; i < 7; i++) begin
      clr;
      e = '0;
      e.valid = 1'b1;
      e.kind = KIND_CACHE;
      e.uc = ue_t[i] != 8'h00;
      e.ce_ways = ce_t[i];
      e.ue_ways = ue_t[i];
      e.tag_ways = tg_t[i];
      ev(e, 1);
      rd(OFS_STAT_LO, d);
      `CHK("cache code", {CACHE_FIXED, 2'h0, cd_t[i], 16'h0000}, d)
      rd(OFS_STAT_HI, d);
      `CHK("event count", cn_t[i], d[7:0])
    end
    $display("test cache codes done");
    clr;
    e = '0;
    e.valid = 1'b1;
    e.kind = KIND_CTL;
    e.msec = 16'h0001;
    e.syn_valid = 1'b1;
    e.syndrome = 8'hA5;
    e.misc_valid = 1'b1;
    e.misc_fmt = 2'h2;
    e.health = 2'h1;
    ev(e, 1);
    repeat (20) @(posedge clk);
    rd(OFS_STAT_HI, d);
    `CHK("info field", 32'h883A_5205, d)
    wr(OFS_STAT_HI, 32'h7FFF_FFFF, 4'hF);
    rd(OFS_STAT_HI, d);
    `CHK("ignored write", 32'h883A_5205, d)
    `CHK("write resp", RESP_OKAY, br)
    clr;
    e.kind = KIND_BUS;
    e.uc = 1'b1;
    e.syndrome = 8'h5A;
    e.misc_valid = 1'b0;
    e.health = 2'h2;
    ev(e, 1);
    e.kind = KIND_CTL;
    e.uc = 1'b0;
    ev(e, 260);
    rd(OFS_STAT_HI, d);
    `CHK("uc kept saturated", 32'hA000_00FF, d)
    clr;
    rd(OFS_STAT_HI, d);
    `CHK("valid cleared", 9'h0FF, {d[31], d[7:0]})
    // Unaligned offset is unmapped: error response, no side effect on the interrupt bits
    wr(4'h2, 32'hFFFF_FFFF, 4'hF);
    `CHK("unmapped wr", RESP_SLVERR, br)
    rd(4'h2, d);
    `CHK("unmapped rd", {RESP_SLVERR, 32'h0000_0000}, {rr, d})
    $display("test info field done");
    rd(OFS_IRQ_STAT, d);
    `CHK("irq status", 32'h0000_001F, d)
    wr(OFS_IRQ_MASK, 32'h0000_001F, 4'hF);
    @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    wr(OFS_IRQ_STAT, 32'h0000_001F, 4'h1);
    @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    rd(OFS_IRQ_STAT, d);
    `CHK("irq cleared", 32'h0000_0000, d)
    wr(OFS_IRQ_MASK, 32'h0000_0004, 4'hF);
    ev(e, 1);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h0000_0002, 4'hF);
    @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    $display("test irq done");
    // Cold reset in mid-run must clear the saturated counter and the interrupt state
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_STAT_HI, d);
    `CHK("cold reset hi", 32'h0000_0000, d)
    rd(OFS_IRQ_STAT, d);
    `CHK("cold reset irq", 32'h0000_0000, d)
    `CHK("cold reset line", 1'b0, irq)
    $display("test cold reset done");
    final_report;
  end
endmodule
bind mcl_logger mcl_logger_checker mcl_logger_checker_i (
  .clk       (clk),
  .rst       (rst),
  .evt       (evt),
  .s_araddr  (s_araddr),
  .s_arvalid (s_arvalid),
  .s_arready (s_arready),
  .s_rvalid  (s_rvalid),
  .s_rdata   (s_rdata)
);
`default_nettype wire
